// ---- logic/mode_setup_pkg.sv ----
// constants for the secured mode select and miscellaneous setup block
// assumes 16-bit spi frames: [15:14] command, [13:9] register, [8] parity, [7:0] data
package mode_setup_pkg;
  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int FRAME_W = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int PAR_BIT = 8;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [4:0] ADDR_MISC = 5'h08;
  localparam logic [4:0] ADDR_SPECIAL = 5'h09;
  localparam logic [15:0] SPECIAL_READ_CMD = 16'h1300;
  localparam logic [3:0] BIT_CNT_LAST = 4'hF;
  // ************************************************************
  // misc setup fields
  // ************************************************************
  localparam int MISC_LP_CHECK = 7;
  localparam int MISC_PARITY = 6;
  localparam int MISC_INT_LEVEL = 5;
  localparam int MISC_INT_SHORT = 4;
  localparam int MISC_INT_FLASH = 3;
  localparam int MISC_RES_EN = 2;
  localparam int MISC_RES_HI = 1;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;
  // resistor variants
  localparam logic [1:0] VAR_B3 = 2'h0;
  localparam logic [1:0] VAR_B2 = 2'h1;
  localparam logic [1:0] VAR_B1 = 2'h2;
  localparam logic [1:0] VAR_A = 2'h3;
  // ************************************************************
  // special mode fields
  // ************************************************************
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int CODE_W = 6;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_SETUP = 2'h1;
  localparam logic [1:0] SEL_FLASH = 2'h2;
  localparam logic [5:0] SAFE_CODE_MASK = 6'h0F;
  localparam logic [2:0] LP_CODE_ZERO = 3'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int INT_LONG_US = 100;
  localparam int INT_SHORT_US = 25;
  localparam logic [11:0] INT_LONG_CYC = 12'((INT_LONG_US * CLK_HZ) / 1000000);
  localparam logic [11:0] INT_SHORT_CYC = 12'((INT_SHORT_US * CLK_HZ) / 1000000);
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] CNT_ONE = 12'h001;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  // device modes
  typedef enum logic [3:0] {
    MODE_RESET = 4'h1,
    MODE_SETUP = 4'h2,
    MODE_NORMAL = 4'h4,
    MODE_FLASH = 4'h8
  } dev_mode_t;
endpackage

// ---- logic/mode_setup.sv ----
// spi slave for the special mode and misc setup registers, mode state, interrupt pulse shaping
// assumes spi mode 0 (sample on rising sclk, shift on falling), frames of exactly 16 clocks
`timescale 1ns/100ps

module mode_setup (
  // system
  input wire logic ref_clk,
  input wire logic reset,
  // spi link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // mode control from other blocks
  input wire logic go_normal,
  input wire logic reset_done,
  input wire logic wd_half,
  output mode_setup_pkg::dev_mode_t dev_mode,
  output logic long_wd_allow,
  // low power entry
  input wire logic lp_req,
  input wire logic [2:0] lp_code,
  output logic lp_grant,
  // interrupts
  input wire logic int_event,
  input wire logic int_release,
  output logic int_n,
  // fail-safe resistor
  input wire logic [1:0] hw_variant,
  input wire logic flag_clear,
  output logic [1:0] safe_variant,
  output logic dbg_res_flag,
  output logic fault_n,
  // register view
  output logic [7:0] misc_setup,
  output logic [7:0] special_mode_reg
);
  import mode_setup_pkg::*;

  function automatic logic [5:0] expected_code(input logic [5:0] code);
    expected_code = ~code;
  endfunction

  // ************************************************************
  // spi link domain
  // ************************************************************
  logic [3:0] bit_cnt_q;
  logic [14:0] shift_q;
  logic [15:0] frame_q;
  logic frame_tgl_q;
  logic miso_q;
  logic [5:0] code_q;
  logic [15:0] rsp;

  assign rsp = {10'h000, code_q};

  // counter restarts while chip select is released, so every frame starts aligned
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sclk) begin
    shift_q <= {shift_q[13:0], mosi};
  end

  always_ff @(posedge sclk) begin
    if (bit_cnt_q == BIT_CNT_LAST) begin
      frame_q <= {shift_q, mosi};
    end
  end

  // reset reaches the toggle cleanly only while sclk stands still between frames
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      frame_tgl_q <= 1'b0;
    end else if (bit_cnt_q == BIT_CNT_LAST) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // code_q only changes after a read frame has finished, so it is steady during a frame
  // top response bit is always zero, so it stands on miso before the first sclk edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= rsp[BIT_CNT_LAST - bit_cnt_q];
    end
  end

  assign miso = miso_q;
  assign miso_oe = ~cs_n;

  // ************************************************************
  // frame crossing into ref_clk
  // ************************************************************
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic [1:0] hw_s1_q, hw_s2_q;
  logic frame_new;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      hw_s1_q <= VAR_B3;
      hw_s2_q <= VAR_B3;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      hw_s1_q <= hw_variant;
      hw_s2_q <= hw_s1_q;
    end
  end

  assign frame_new = tgl_s2_q ^ tgl_s3_q;

  // ************************************************************
  // frame decode
  // ************************************************************
  logic [1:0] f_cmd;
  logic [4:0] f_addr;
  logic [7:0] f_data;
  logic par_ok;
  logic is_code_read, is_misc_wr, is_spec_wr;
  logic code_full, code_safe;
  logic [5:0] last_code_q;
  logic [5:0] code_inv;
  dev_mode_t mode_q;
  logic armed_q;
  logic [7:0] misc_q;

  assign f_cmd = frame_q[CMD_HI:CMD_LO];
  assign f_addr = frame_q[ADDR_HI:ADDR_LO];
  assign f_data = frame_q[7:0];
  // parity bit makes the count of ones in the frame odd
  assign par_ok = ~misc_q[MISC_PARITY] | (^frame_q);
  assign is_code_read = frame_new & (frame_q == SPECIAL_READ_CMD);
  assign is_misc_wr = frame_new & (f_cmd == CMD_WRITE) & (f_addr == ADDR_MISC) & par_ok;
  assign is_spec_wr = frame_new & (f_cmd == CMD_WRITE) & (f_addr == ADDR_SPECIAL) & par_ok & armed_q;
  assign code_inv = expected_code(last_code_q);
  assign code_full = f_data[CODE_W-1:0] == code_inv;
  assign code_safe = f_data[CODE_W-1:0] == (last_code_q ^ SAFE_CODE_MASK);

  // ************************************************************
  // random code
  // ************************************************************
  logic [15:0] lfsr_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? LFSR_TAPS : 16'h0000);
    end
  end

  // the code shown on a read was drawn at the previous read; writes are judged against it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      code_q <= 6'h00;
      last_code_q <= 6'h00;
    end else if (is_code_read) begin
      last_code_q <= code_q;
      code_q <= lfsr_q[CODE_W-1:0];
    end
  end

  // only the frame right after the code read may act on it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (frame_new) begin
      armed_q <= is_code_read;
    end
  end

  // ************************************************************
  // mode state
  // ************************************************************
  logic [1:0] sel;
  logic [7:0] spec_q;

  assign sel = f_data[SEL_HI:SEL_LO];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= MODE_SETUP;
    end else begin
      case (mode_q)
        MODE_RESET: begin
          if (reset_done) begin
            mode_q <= MODE_SETUP;
          end
        end
        MODE_SETUP: begin
          if (go_normal) begin
            mode_q <= MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          if (is_spec_wr && code_full) begin
            if (sel == SEL_SETUP) begin
              mode_q <= MODE_SETUP;
            end else if (sel == SEL_RESET) begin
              mode_q <= MODE_RESET;
            end else if (sel == SEL_FLASH) begin
              mode_q <= MODE_FLASH;
            end
          end
        end
        MODE_FLASH: begin
          if (reset_done) begin
            mode_q <= MODE_SETUP;
          end
        end
        default: begin
          mode_q <= MODE_SETUP;
        end
      endcase
    end
  end

  assign dev_mode = mode_q;
  assign long_wd_allow = mode_q == MODE_FLASH;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spec_q <= SPECIAL_RESET;
    end else if (is_spec_wr && (code_full || code_safe)) begin
      spec_q <= f_data;
    end
  end

  assign special_mode_reg = spec_q;

  // fault pin stays low once activated, until reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fault_n <= 1'b1;
    end else if (is_spec_wr && code_safe && sel == SEL_SETUP && mode_q == MODE_SETUP) begin
      fault_n <= 1'b0;
    end
  end

  // ************************************************************
  // misc setup register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      misc_q <= MISC_RESET;
    end else if (is_misc_wr && mode_q == MODE_SETUP) begin
      misc_q <= f_data;
    end
  end

  assign misc_setup = misc_q;

  // ************************************************************
  // low power entry
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lp_grant <= 1'b0;
    end else begin
      lp_grant <= lp_req & (~misc_q[MISC_LP_CHECK] | (lp_code == code_inv[2:0]));
    end
  end

  // ************************************************************
  // fail-safe resistor
  // ************************************************************
  logic res_en;
  logic [1:0] res_var;

  assign res_en = misc_q[MISC_RES_EN];
  assign res_var = misc_q[MISC_RES_HI:0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      safe_variant <= VAR_B3;
    end else begin
      safe_variant <= res_en ? res_var : hw_s2_q;
    end
  end

  // a mismatch in the clearing cycle keeps the flag set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dbg_res_flag <= 1'b0;
    end else if (res_en && hw_s2_q != res_var) begin
      dbg_res_flag <= 1'b1;
    end else if (flag_clear) begin
      dbg_res_flag <= 1'b0;
    end
  end

  // ************************************************************
  // interrupt output
  // ************************************************************
  logic int_trig;
  logic [11:0] pulse_cnt_q;
  logic level_q;

  assign int_trig = int_event | (wd_half & misc_q[MISC_INT_FLASH] & (mode_q == MODE_FLASH));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pulse_cnt_q <= CNT_ZERO;
    end else if (int_trig && !misc_q[MISC_INT_LEVEL]) begin
      pulse_cnt_q <= misc_q[MISC_INT_SHORT] ? INT_SHORT_CYC : INT_LONG_CYC;
    end else if (pulse_cnt_q != CNT_ZERO) begin
      pulse_cnt_q <= pulse_cnt_q - CNT_ONE;
    end
  end

  // a new event in the release cycle keeps the line low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_q <= 1'b0;
    end else if (int_trig && misc_q[MISC_INT_LEVEL]) begin
      level_q <= 1'b1;
    end else if (int_release || !misc_q[MISC_INT_LEVEL]) begin
      level_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(level_q | (pulse_cnt_q != CNT_ZERO));
    end
  end

endmodule

// ---- sim/mode_setup_monitor.sv ----
// checker for the mode and setup block
// assumes it is bound to mode_setup and watches the ref_clk domain only
`timescale 1ns/100ps
module mode_setup_monitor
  import mode_setup_pkg::*;
(
  // system
  input wire logic ref_clk,
  input wire logic reset,
  // watched ports
  input wire logic int_event,
  input wire logic int_release,
  input wire logic int_n,
  input wire logic lp_req,
  input wire logic lp_grant,
  input wire logic long_wd_allow,
  input wire logic fault_n,
  input wire logic [1:0] safe_variant,
  input wire logic [7:0] misc_setup,
  input dev_mode_t dev_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [11:0] low_q;
  // counts how long the interrupt line has been low
  always_ff @(posedge ref_clk) begin
    low_q <= int_n ? CNT_ZERO : low_q + CNT_ONE;
  end
  int_start_a:
    assert property (int_event && int_n |-> ##2 !int_n) else $error("interrupt not raised");
  pulse_len_a:
    assert property ($rose(int_n) && !misc_setup[MISC_INT_LEVEL] |->
      low_q == (misc_setup[MISC_INT_SHORT] ? INT_SHORT_CYC : INT_LONG_CYC)) else $error("pulse length");
  level_rel_a:
    assert property ($rose(int_n) && misc_setup[MISC_INT_LEVEL] |->
      $past(int_release) || $past(int_release, 2)) else $error("level interrupt ended early");
  lp_free_a:
    assert property (lp_req && !misc_setup[MISC_LP_CHECK] |=> lp_grant) else $error("no grant");
  flash_wd_a:
    assert property (long_wd_allow == (dev_mode == MODE_FLASH)) else $error("long watchdog flag");
  override_a:
    assert property (misc_setup[MISC_RES_EN] && $stable(misc_setup) |=>
      safe_variant == $past(misc_setup[1:0])) else $error("override ignored");
  fault_hold_a:
    assert property (!fault_n |=> !fault_n) else $error("fault released");
  misc_gate_a:
    assert property ($changed(misc_setup) |-> $past(dev_mode) == MODE_SETUP) else $error("misc outside setup");
  fault_setup_a:
    assert property ($fell(fault_n) |-> $past(dev_mode) == MODE_SETUP) else $error("fault outside setup");
  flash_entry_a:
    assert property ($changed(dev_mode) && dev_mode == MODE_FLASH |-> $past(dev_mode) == MODE_NORMAL)
      else $error("flash not entered from normal");
  cover property (!fault_n);
  cover property (dev_mode == MODE_FLASH);
  cover property (lp_grant);
endmodule

bind mode_setup mode_setup_monitor i_mode_setup_monitor (.ref_clk(ref_clk), .reset(reset),
  .int_event(int_event), .int_release(int_release), .int_n(int_n), .lp_req(lp_req),
  .lp_grant(lp_grant), .long_wd_allow(long_wd_allow), .fault_n(fault_n),
  .safe_variant(safe_variant), .misc_setup(misc_setup), .dev_mode(dev_mode));

// ---- sim/spi_host.sv ----
// host side spi master model, mode 0, msb first
// assumes 16-bit frames; sclk stands still between frames
`timescale 1ns/100ps
module spi_host (
  // spi link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // one whole frame at 12 ns a bit, miso taken at the rising edge; released mosi shows the inverse of its last bit
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #3 sclk = 1'b1;
      rx[i] = miso;
      #6 sclk = 1'b0;
      #3;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ---- sim/secured_mode_select_and_misc_setup_test.sv ----
// testbench for the mode and setup block
// assumes the host model drives the link and the monitor is bound
`timescale 1ns/100ps
module secured_mode_select_and_misc_setup_test;
  import mode_setup_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, go_normal = 1'b0, reset_done = 1'b0, wd_half = 1'b0;
  logic lp_req = 1'b0, int_event = 1'b0, int_release = 1'b0, flag_clear = 1'b0, par_on = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, long_wd_allow, lp_grant, int_n, dbg_res_flag, fault_n;
  logic [2:0] lp_code = 3'h0;
  logic [1:0] hw_variant = 2'h0, safe_variant;
  logic [7:0] misc_setup, special_mode_reg;
  logic [15:0] rx;
  dev_mode_t dev_mode;
  int err_total = 0, total_checks = 0;
  mode_setup i_mode_setup (.ref_clk(ref_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .go_normal(go_normal), .reset_done(reset_done), .wd_half(wd_half),
    .dev_mode(dev_mode), .long_wd_allow(long_wd_allow), .lp_req(lp_req), .lp_code(lp_code),
    .lp_grant(lp_grant), .int_event(int_event), .int_release(int_release), .int_n(int_n),
    .hw_variant(hw_variant), .flag_clear(flag_clear), .safe_variant(safe_variant),
    .dbg_res_flag(dbg_res_flag), .fault_n(fault_n), .misc_setup(misc_setup),
    .special_mode_reg(special_mode_reg));
  spi_host i_spi_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  always #25 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] frm(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {CMD_WRITE, a, 1'b0, d};
    if (par_on) f[PAR_BIT] = ~^f;
    return f;
  endfunction
  task automatic frame(input logic [15:0] tx);
    i_spi_host.xfer(tx, rx);
    step(6);
  endtask
  task automatic pulse(input int k);
    case (k)
      0: go_normal = 1'b1;
      1: reset_done = 1'b1;
      2: int_event = 1'b1;
      3: int_release = 1'b1;
      4: flag_clear = 1'b1;
      default: wd_half = 1'b1;
    endcase
    step(1);
    {go_normal, reset_done, int_event, int_release, flag_clear, wd_half} = 6'h00;
    step(1);
  endtask
  // read the code, then write the selection with the code transformed by x
  task automatic special(input logic [1:0] sel, input logic [5:0] x);
    logic [5:0] c;
    frame(SPECIAL_READ_CMD);
    chk(rx[15:6], 16'h0000);
    c = rx[5:0];
    frame(frm(ADDR_SPECIAL, {sel, ~c ^ x}));
  endtask
  task automatic t_reset;
    chk({misc_setup, special_mode_reg}, 16'h0000);
    chk({dev_mode, int_n, fault_n, dbg_res_flag, lp_grant, safe_variant}, {MODE_SETUP, 4'hC, VAR_B3});
    chk(miso_oe, 1'b0);
  endtask
  task automatic t_resistor;
    hw_variant = VAR_A;
    for (int i = 0; i < 4; i++) begin
      frame(frm(ADDR_MISC, 8'h84 + 8'(i)));
      pulse(4);
      step(4);
      chk({misc_setup, 6'h00, safe_variant}, {8'h84 + 8'(i), 6'h00, 2'(i)});
      chk(dbg_res_flag, i != 3);
    end
    hw_variant = VAR_B2;
    frame(frm(ADDR_MISC, 8'h03));
    step(4);
    chk(safe_variant, VAR_B2);
  endtask
  task automatic t_int;
    int n;
    for (int s = 0; s < 2; s++) begin
      frame(frm(ADDR_MISC, s ? 8'h10 : 8'h00));
      pulse(2);
      n = 0;
      while (int_n === 1'b0 && n < 3000) begin
        n++;
        step(1);
      end
      chk(16'(n), 16'(s ? INT_SHORT_CYC : INT_LONG_CYC));
    end
    frame(frm(ADDR_MISC, 8'h20));
    pulse(2);
    step(2500);
    chk(int_n, 1'b0);
    pulse(3);
    step(2);
    chk(int_n, 1'b1);
  endtask
  task automatic t_parity;
    frame(frm(ADDR_MISC, 8'h40));
    par_on = 1'b1;
    frame(frm(ADDR_MISC, 8'h48) ^ 16'h0100);
    chk(misc_setup, 8'h40);
    frame(frm(ADDR_MISC, 8'h08));
    chk(misc_setup, 8'h08);
    par_on = 1'b0;
  endtask
  task automatic t_lp;
    int g;
    logic [2:0] want;
    g = 0;
    lp_code = 3'h5;
    lp_req = 1'b1;
    step(1);
    lp_req = 1'b0;
    chk(lp_grant, 1'b1);
    frame(frm(ADDR_MISC, 8'h88));
    frame(SPECIAL_READ_CMD);
    want = ~rx[2:0];
    for (int k = 0; k < 8; k++) begin
      lp_code = 3'(k);
      lp_req = 1'b1;
      step(1);
      lp_req = 1'b0;
      if (lp_grant === 1'b1) g++;
      chk(lp_grant, 3'(k) == want);
      step(1);
    end
    chk(16'(g), 16'h0001);
    frame(frm(ADDR_MISC, 8'h08));
  endtask
  task automatic t_modes;
    pulse(5);
    chk(int_n, 1'b1);
    pulse(0);
    frame(frm(ADDR_SPECIAL, 8'h80));
    chk(dev_mode, MODE_NORMAL);
    special(SEL_FLASH, 6'h01);
    chk(dev_mode, MODE_NORMAL);
    special(SEL_FLASH, 6'h00);
    chk({dev_mode, long_wd_allow, special_mode_reg[7:6]}, {MODE_FLASH, 1'b1, SEL_FLASH});
    special(SEL_SETUP, 6'h00);
    chk(dev_mode, MODE_FLASH);
    frame(frm(ADDR_MISC, 8'h00));
    chk(misc_setup, 8'h08);
    pulse(5);
    chk(int_n, 1'b0);
    step(2010);
    pulse(1);
    pulse(0);
    special(SEL_RESET, 6'h00);
    chk(dev_mode, MODE_RESET);
    pulse(1);
    pulse(0);
    special(SEL_SETUP, 6'h30);
    chk({dev_mode, fault_n}, {MODE_NORMAL, 1'b1});
    special(SEL_SETUP, 6'h00);
    chk(dev_mode, MODE_SETUP);
    special(SEL_SETUP, 6'h30);
    chk(fault_n, 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    step(3);
    reset = 1'b0;
    step(1);
    t_reset;
    t_resistor;
    t_int;
    t_parity;
    t_lp;
    t_modes;
    finish_test;
  end
  // cuts a hang short well beyond the expected run
  initial begin
    #1000000;
    err_total++;
    finish_test;
  end
endmodule
